/* logic/glf_line_ctrl.sv */
// gpio interrupt/function control, software reset, infrared and rs-485 direction control
//
// How it works
// - each interrupt enable bit lets its gpio pin raise the interrupt while the pin is an input, zero blocks it
// - a nibble in modem duty ignores its interrupt enable bits
// - writing one to function control bit 3 starts a software reset
// - the software reset bit clears itself when the reset is over
// - function bit 2 turns gpio 3..0 into channel b modem signals
// - function bit 1 turns gpio 7..4 into channel a modem signals
// - unlatched inputs withdraw the interrupt when the level reverts before a read
// - latched inputs keep the interrupt and the causing level until read
// - extra bit 7 picks 3/16 or 1/4 bit-time infrared pulses
// - extra bit 4 hands the rts pin to the transmitter
// - extra bit 5 sets rts level while transmitting versus receiving
// - polarity matters only while automatic direction control is on
// - extra feature register reachable only while special function bit 2 is zero
// - direction bit zero makes a pin an input, one an output
// - state read gives pin levels, state write sets output pin levels
module glf_line_ctrl
   import glf_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [3:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       special_function_reg_bit2_i,
   input  wire logic [7:0] gpio_pin_i,
   output logic      [7:0] gpio_pin_o,
   output logic      [7:0] gpio_pin_oe_n_o,
   input  wire logic       terminal_ready_a_n_i,
   input  wire logic       terminal_ready_b_n_i,
   output logic            ring_indicate_a_n_o,
   output logic            carrier_detect_a_n_o,
   output logic            set_ready_a_n_o,
   output logic            ring_indicate_b_n_o,
   output logic            carrier_detect_b_n_o,
   output logic            set_ready_b_n_o,
   input  wire logic       uart_tx_active_i,
   input  wire logic       uart_rts_n_i,
   output logic            rts_n_o,
   output logic            irda_fast_mode_o,
   output logic      [2:0] irda_pulse_sixteenths_o,
   output logic            gpio_irq_o,
   output logic            soft_rst_o
);

   // single address comparison shared by every strobe decode
   function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] ofs);
      return addr == ofs;
   endfunction

   logic [7:0]   gpio_direction_reg;
   logic [7:0]   gpio_pin_level_reg;
   logic [7:0]   gpio_irq_enable_reg;
   logic [7:0]   gpio_function_control_reg;
   logic [7:0]   extra_feature_control_reg;
   logic [7:0]   pin_meta;
   logic [7:0]   pin_sync;
   glf_srst_type srst_state;
   logic [2:0]   srst_cnt;
   logic         dev_rst;
   logic         extra_open;
   logic         srst_busy;
   logic [7:0]   modem_mask;
   logic [7:0]   eligible;
   logic [7:0]   ctrl_rd_val;
   logic [7:0]   next_rdata;
   logic [7:0]   next_pin_o;
   logic [7:0]   next_oe_n;

   glf_track_if trk ();

   // pins are asynchronous to the bank: two flops before anything looks
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         pin_meta <= STATE_RST;
         pin_sync <= STATE_RST;
      end
      else
      begin
         pin_meta <= gpio_pin_i;
         pin_sync <= pin_meta;
      end
   end

   // the device reset: hardware input or the end of a software reset
   assign dev_rst    = sys_rst_i || (srst_state == SR_DONE);
   assign srst_busy  = (srst_state != SR_IDLE);
   assign extra_open = !special_function_reg_bit2_i;

   // software reset sequencer, returned to idle by the hardware reset input
   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
      begin
         srst_state <= SR_IDLE;
         srst_cnt   <= 3'h0;
         soft_rst_o <= 1'b0;
      end
      else
      begin
         case (srst_state)
            SR_IDLE:
            begin
               if (reg_wr_i && addr_hit(reg_addr_i, OFS_FUNC) && reg_wdata_i[FUNC_SOFT_RST_BIT])
               begin
                  srst_state <= SR_BUSY;
                  srst_cnt   <= SOFT_RST_CNT - 3'h1;
                  soft_rst_o <= 1'b1;
               end
            end
            SR_BUSY:
            begin
               if (srst_cnt == 3'h0)
               begin
                  srst_state <= SR_DONE;
                  soft_rst_o <= 1'b0;
               end
               else
                  srst_cnt <= srst_cnt - 3'h1;
            end
            SR_DONE:
               srst_state <= SR_IDLE;
            default:
            begin
               srst_state <= SR_IDLE;
               soft_rst_o <= 1'b0;
            end
         endcase
      end
   end

   // gpio direction and output level registers
   always_ff @(posedge ref_clk_i)
   begin
      if (dev_rst)
      begin
         gpio_direction_reg <= DIR_RST;
         gpio_pin_level_reg <= STATE_RST;
      end
      else if (reg_wr_i)
      begin
         if (addr_hit(reg_addr_i, OFS_DIR))
            gpio_direction_reg <= reg_wdata_i;
         if (addr_hit(reg_addr_i, OFS_STATE))
            gpio_pin_level_reg <= reg_wdata_i;
      end
   end

   // interrupt enable and function control; function bits 3 and above are never stored
   always_ff @(posedge ref_clk_i)
   begin
      if (dev_rst)
      begin
         gpio_irq_enable_reg       <= IRQ_EN_RST;
         gpio_function_control_reg <= FUNC_RST;
      end
      else if (reg_wr_i)
      begin
         if (addr_hit(reg_addr_i, OFS_IRQ_EN))
            gpio_irq_enable_reg <= reg_wdata_i;
         if (addr_hit(reg_addr_i, OFS_FUNC))
            gpio_function_control_reg <= reg_wdata_i & FUNC_CFG_MASK;
      end
   end

   // extra feature control; a write while special function bit 2 is set is dropped
   always_ff @(posedge ref_clk_i)
   begin
      if (dev_rst)
         extra_feature_control_reg <= EXTRA_RST;
      else if (reg_wr_i && addr_hit(reg_addr_i, OFS_EXTRA) && extra_open)
         extra_feature_control_reg <= reg_wdata_i & EXTRA_WMASK;
   end

   // nibbles in modem duty take no part in gpio interrupts
   assign modem_mask = {{4{gpio_function_control_reg[FUNC_MODEM_HI_BIT]}},
                        {4{gpio_function_control_reg[FUNC_MODEM_LO_BIT]}}};
   assign eligible   = gpio_irq_enable_reg & ~gpio_direction_reg & ~modem_mask;

   assign trk.live_lvl = pin_sync;
   assign trk.eligible = eligible;
   assign trk.latch_en = gpio_function_control_reg[FUNC_LATCH_BIT];
   assign trk.state_rd = reg_rd_i && addr_hit(reg_addr_i, OFS_STATE);
   assign trk.dev_rst  = dev_rst;

   glf_pin_track u_track
   (
      .ref_clk_i (ref_clk_i),
      .trk       (trk)
   );

   // interrupt re-gated so clearing an enable takes effect at once
   always_ff @(posedge ref_clk_i)
   begin
      if (dev_rst)
         gpio_irq_o <= 1'b0;
      else
         gpio_irq_o <= |(trk.pending & eligible);
   end

   // control read value: reset bit shows the sequencer, upper bits reserved
   assign ctrl_rd_val = {4'h0, srst_busy, gpio_function_control_reg[2:0]};

   // read data mux; unmapped offsets and a locked extra register read zero
   always_comb
   begin
      next_rdata = 8'h00;
      case (reg_addr_i)
         OFS_DIR:    next_rdata = gpio_direction_reg;
         OFS_STATE:  next_rdata = trk.shown_lvl;
         OFS_IRQ_EN: next_rdata = gpio_irq_enable_reg;
         OFS_FUNC:   next_rdata = ctrl_rd_val;
         OFS_EXTRA:  next_rdata = extra_open ? extra_feature_control_reg : 8'h00;
         default:    next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= 8'h00;
      else if (reg_rd_i)
         reg_rdata_o <= next_rdata;
   end

   // pin drive: gpio nibbles follow direction, modem nibbles drive only dtr
   always_comb
   begin
      next_pin_o = gpio_pin_level_reg;
      next_oe_n  = ~gpio_direction_reg;
      if (gpio_function_control_reg[FUNC_MODEM_LO_BIT])
      begin
         next_pin_o[3:0]     = 4'hf;
         next_oe_n[3:0]      = 4'hf;
         next_pin_o[MDM_DTR] = terminal_ready_b_n_i;
         next_oe_n[MDM_DTR]  = 1'b0;
      end
      if (gpio_function_control_reg[FUNC_MODEM_HI_BIT])
      begin
         next_pin_o[7:4]              = 4'hf;
         next_oe_n[7:4]               = 4'hf;
         next_pin_o[NIB_HI + MDM_DTR] = terminal_ready_a_n_i;
         next_oe_n[NIB_HI + MDM_DTR]  = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (dev_rst)
      begin
         gpio_pin_o      <= STATE_RST;
         gpio_pin_oe_n_o <= 8'hff;
      end
      else
      begin
         gpio_pin_o      <= next_pin_o;
         gpio_pin_oe_n_o <= next_oe_n;
      end
   end

   // modem status to the uart; inactive high while the nibble is plain gpio
   always_ff @(posedge ref_clk_i)
   begin
      if (dev_rst)
      begin
         ring_indicate_b_n_o  <= 1'b1;
         carrier_detect_b_n_o <= 1'b1;
         set_ready_b_n_o      <= 1'b1;
         ring_indicate_a_n_o  <= 1'b1;
         carrier_detect_a_n_o <= 1'b1;
         set_ready_a_n_o      <= 1'b1;
      end
      else
      begin
         ring_indicate_b_n_o  <= !modem_mask[0] || pin_sync[MDM_RI];
         carrier_detect_b_n_o <= !modem_mask[0] || pin_sync[MDM_CD];
         set_ready_b_n_o      <= !modem_mask[0] || pin_sync[MDM_DSR];
         ring_indicate_a_n_o  <= !modem_mask[4] || pin_sync[NIB_HI + MDM_RI];
         carrier_detect_a_n_o <= !modem_mask[4] || pin_sync[NIB_HI + MDM_CD];
         set_ready_a_n_o      <= !modem_mask[4] || pin_sync[NIB_HI + MDM_DSR];
      end
   end

   // rts: transmitter owns it only in automatic mode, polarity only then
   always_ff @(posedge ref_clk_i)
   begin
      if (dev_rst)
         rts_n_o <= 1'b1;
      else if (extra_feature_control_reg[EXTRA_AUTO_DIR_BIT])
         rts_n_o <= extra_feature_control_reg[EXTRA_DIR_POL_BIT] ?
                    uart_tx_active_i : !uart_tx_active_i;
      else
         rts_n_o <= uart_rts_n_i;
   end

   // infrared pulse selection for the encoder
   always_ff @(posedge ref_clk_i)
   begin
      if (dev_rst)
      begin
         irda_fast_mode_o        <= 1'b0;
         irda_pulse_sixteenths_o <= IRDA_PULSE_STD;
      end
      else
      begin
         irda_fast_mode_o        <= extra_feature_control_reg[EXTRA_IRDA_BIT];
         irda_pulse_sixteenths_o <= extra_feature_control_reg[EXTRA_IRDA_BIT] ?
                                    IRDA_PULSE_FAST : IRDA_PULSE_STD;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   chk_irq_enable_gate: assert property (
      (gpio_irq_enable_reg == 8'h00) |=> !gpio_irq_o)
      else $error("gpio interrupt raised with all enables clear");

   chk_irq_modem_mask: assert property (
      (modem_mask == 8'hff && !dev_rst) |=> !gpio_irq_o)
      else $error("gpio interrupt raised with both nibbles in modem duty");

   chk_soft_rst_len: assert property (
      $rose(soft_rst_o) |-> soft_rst_o[*4] ##1 !soft_rst_o)
      else $error("software reset pulse has the wrong length");

   chk_soft_bit_clear: assert property (
      $fell(soft_rst_o) |=> (ctrl_rd_val[FUNC_SOFT_RST_BIT] == 1'b0) && (ctrl_rd_val[2:0] == 3'h0))
      else $error("software reset bit or control bits not cleared after reset");

   chk_lower_modem_drive: assert property (
      (gpio_function_control_reg[FUNC_MODEM_LO_BIT] && !dev_rst) |=> (gpio_pin_oe_n_o[3:0] == 4'hd))
      else $error("lower modem nibble drives the wrong pins");

   chk_upper_dir_drive: assert property (
      (!gpio_function_control_reg[FUNC_MODEM_HI_BIT] && !dev_rst)
      |=> (gpio_pin_oe_n_o[7:4] == ~$past(gpio_direction_reg[7:4])))
      else $error("upper gpio output enables do not follow direction");

   chk_irda_pulse: assert property (
      (extra_feature_control_reg[EXTRA_IRDA_BIT] && !dev_rst) |=> (irda_pulse_sixteenths_o == 3'h4))
      else $error("fast infrared mode without quarter pulse");

   chk_rts_auto_pol: assert property (
      (extra_feature_control_reg[EXTRA_AUTO_DIR_BIT] && extra_feature_control_reg[EXTRA_DIR_POL_BIT]
       && !dev_rst) |=> (rts_n_o == $past(uart_tx_active_i)))
      else $error("inverted rs-485 direction level wrong");

   chk_rts_manual: assert property (
      (!extra_feature_control_reg[EXTRA_AUTO_DIR_BIT] && !dev_rst) |=> (rts_n_o == $past(uart_rts_n_i)))
      else $error("rts taken by transmitter while automatic mode is off");

   chk_extra_locked: assert property (
      (reg_wr_i && addr_hit(reg_addr_i, OFS_EXTRA) && special_function_reg_bit2_i && !dev_rst)
      |=> $stable(extra_feature_control_reg))
      else $error("extra feature register written while locked");

   chk_state_read: assert property (
      (reg_rd_i && addr_hit(reg_addr_i, OFS_STATE)) |=> (reg_rdata_o == $past(trk.shown_lvl)))
      else $error("state read does not return pin levels");

   chk_reserved_zero: assert property (
      (reg_rd_i && addr_hit(reg_addr_i, OFS_FUNC)) |=> (reg_rdata_o[7:4] == 4'h0))
      else $error("reserved control bits read nonzero");

endmodule

/* logic/glf_pkg.sv */
// constants, register map and types of the gpio and line feature control bank
package glf_pkg;

   // register offsets on the host register port
   localparam logic [3:0] OFS_DIR    = 4'ha;
   localparam logic [3:0] OFS_STATE  = 4'hb;
   localparam logic [3:0] OFS_IRQ_EN = 4'hc;
   localparam logic [3:0] OFS_FUNC   = 4'he;
   localparam logic [3:0] OFS_EXTRA  = 4'hf;

   // reset values
   localparam logic [7:0] DIR_RST    = 8'h00;
   localparam logic [7:0] STATE_RST  = 8'hff;
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] FUNC_RST   = 8'h00;
   localparam logic [7:0] EXTRA_RST  = 8'h00;

   // gpio function control fields
   localparam int unsigned FUNC_LATCH_BIT    = 0;
   localparam int unsigned FUNC_MODEM_HI_BIT = 1;
   localparam int unsigned FUNC_MODEM_LO_BIT = 2;
   localparam int unsigned FUNC_SOFT_RST_BIT = 3;
   localparam logic [7:0]  FUNC_CFG_MASK     = 8'h07;

   // extra feature control fields
   localparam int unsigned EXTRA_AUTO_DIR_BIT = 4;
   localparam int unsigned EXTRA_DIR_POL_BIT  = 5;
   localparam int unsigned EXTRA_IRDA_BIT     = 7;
   localparam logic [7:0]  EXTRA_WMASK        = 8'hb0;

   // modem signal position inside a nibble (upper nibble channel a, lower channel b)
   localparam int unsigned MDM_DSR = 0;
   localparam int unsigned MDM_DTR = 1;
   localparam int unsigned MDM_CD  = 2;
   localparam int unsigned MDM_RI  = 3;
   localparam int unsigned NIB_HI  = 4;

   // infrared pulse width in sixteenths of a bit time
   localparam logic [2:0] IRDA_PULSE_STD  = 3'h3;
   localparam logic [2:0] IRDA_PULSE_FAST = 3'h4;

   // software reset pulse length
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned SOFT_RST_NS     = 160;
   localparam int unsigned SOFT_RST_CYC    = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0]  SOFT_RST_CNT    = 3'(SOFT_RST_CYC < 1 ? 1 : SOFT_RST_CYC);

   typedef enum logic [1:0]
   {
      SR_IDLE = 2'b00,
      SR_BUSY = 2'b01,
      SR_DONE = 2'b10
   } glf_srst_type;

endpackage

/* logic/glf_track_if.sv */
// carrier between the control bank and its gpio input tracker
interface glf_track_if;
   logic [7:0] live_lvl;
   logic [7:0] eligible;
   logic       latch_en;
   logic       state_rd;
   logic       dev_rst;
   logic [7:0] shown_lvl;
   logic [7:0] pending;

   modport tracker
   (
      input  live_lvl,
      input  eligible,
      input  latch_en,
      input  state_rd,
      input  dev_rst,
      output shown_lvl,
      output pending
   );

   modport owner
   (
      output live_lvl,
      output eligible,
      output latch_en,
      output state_rd,
      output dev_rst,
      input  shown_lvl,
      input  pending
   );
endinterface

/* logic/glf_pin_track.sv */
// gpio input change tracker: pending flags, latched levels, last-read baseline
module glf_pin_track
   import glf_pkg::*;
(
   input wire logic         ref_clk_i,
   glf_track_if.tracker     trk
);

   logic [7:0] base;
   logic [7:0] held;
   logic [7:0] pend;
   logic [7:0] changed;
   logic [7:0] next_pend;

   // departure from the level the host saw last
   assign changed = trk.live_lvl ^ base;

   // latched: set sticks until read, the read clear wins over a set of a flag already pending
   // unlatched: flag simply follows the difference, so a revert withdraws it
   always_comb
   begin
      if (trk.latch_en)
         next_pend = (pend & ~{8{trk.state_rd}}) | (trk.eligible & changed & ~pend);
      else
         next_pend = trk.eligible & changed;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (trk.dev_rst)
         pend <= 8'h00;
      else
         pend <= next_pend;
   end

   // hold the level that raised a latched flag; track live otherwise
   always_ff @(posedge ref_clk_i)
   begin
      if (trk.dev_rst)
         held <= STATE_RST;
      else
         held <= (trk.latch_en ? pend : 8'h00) & held | ~(trk.latch_en ? pend : 8'h00) & trk.live_lvl;
   end

   // the host read moves the baseline to what it was shown
   always_ff @(posedge ref_clk_i)
   begin
      if (trk.dev_rst)
         base <= STATE_RST;
      else if (trk.state_rd)
         base <= trk.shown_lvl;
   end

   assign trk.shown_lvl = trk.latch_en ? ((pend & held) | (~pend & trk.live_lvl)) : trk.live_lvl;
   assign trk.pending   = pend;

   chk_latch_sticky: assert property (@(posedge ref_clk_i) disable iff (trk.dev_rst)
      (trk.latch_en && !trk.state_rd && $past(trk.latch_en)) |=> ((pend & $past(pend)) == $past(pend)))
      else $error("latched gpio flag dropped without a read");

   chk_unlatched_follow: assert property (@(posedge ref_clk_i) disable iff (trk.dev_rst)
      !trk.latch_en |=> (pend == $past(trk.eligible & changed)))
      else $error("unlatched gpio flag does not follow the input");

endmodule

/* testbench/glf_host_model.sv */
// host processor model driving the register port of the control bank
module glf_host_model
   import glf_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic      [3:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic            reg_rd_o,
   output logic      [7:0] reg_wdata_o,
   output logic            sfr_bit2_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus at time zero
   initial
   begin
      reg_addr_o  = 4'h0;
      reg_wr_o    = 1'b0;
      reg_rd_o    = 1'b0;
      reg_wdata_o = 8'h00;
      sfr_bit2_o  = 1'b0;
   end

   // strobe held for one taking edge, then released
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_o  = a;
      reg_wdata_o = d;
      reg_wr_o    = 1'b1;
      @(negedge ref_clk_i);
      reg_wr_o    = 1'b0;
      reg_wdata_o = ~d; // released bus must not show stale data
   endtask

   // read data is registered, so it is taken one edge after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_o = a;
      reg_rd_o   = 1'b1;
      @(negedge ref_clk_i);
      reg_rd_o = 1'b0;
      d        = reg_rdata_i;
   endtask

   // special function bit 2 must be clear before the extra register is used
   task automatic lock(input logic v);
      @(negedge ref_clk_i);
      sfr_bit2_o = v;
   endtask
endmodule

/* testbench/gpio_and_line_feature_control_bench.sv */
// self-checking bench of the gpio and line feature control bank
module gpio_and_line_feature_control_bench
   import glf_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   logic       clk    = 1'b0;
   logic       rst    = 1'b1;
   logic [7:0] pins   = 8'hff;
   logic       tx_act = 1'b0;
   logic       rts_in = 1'b1;
   logic [3:0] addr;
   logic       wr;
   logic       rd;
   logic       special_function_reg;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] pin_o;
   logic [7:0] oe_n;
   logic       ri_a;
   logic       ri_b;
   logic       cd_a;
   logic       cd_b;
   logic       dsr_a;
   logic       dsr_b;
   logic       dtr_a  = 1'b1;
   logic       dtr_b  = 1'b1;
   logic       rts_n;
   logic       irda_fast;
   logic [2:0] pulse;
   logic       irq;
   logic       srst;
   int         n_fail      = 0;
   int         checks_done = 0;

   // 25 MHz clock
   initial
   begin
      forever #20 clk = ~clk;
   end

   glf_host_model u_glf_host_model (
      .ref_clk_i   (clk),
      .reg_rdata_i (rdata),
      .reg_addr_o  (addr),
      .reg_wr_o    (wr),
      .reg_rd_o    (rd),
      .reg_wdata_o (wdata),
      .sfr_bit2_o  (special_function_reg)
   );

   // modem dtr inputs idle high until the modem scenario pulls them low
   glf_line_ctrl u_glf_line_ctrl (
      .ref_clk_i                   (clk),
      .sys_rst_i                   (rst),
      .reg_addr_i                  (addr),
      .reg_wr_i                    (wr),
      .reg_rd_i                    (rd),
      .reg_wdata_i                 (wdata),
      .reg_rdata_o                 (rdata),
      .special_function_reg_bit2_i (special_function_reg),
      .gpio_pin_i                  (pins),
      .gpio_pin_o                  (pin_o),
      .gpio_pin_oe_n_o             (oe_n),
      .terminal_ready_a_n_i        (dtr_a),
      .terminal_ready_b_n_i        (dtr_b),
      .ring_indicate_a_n_o         (ri_a),
      .carrier_detect_a_n_o        (cd_a),
      .set_ready_a_n_o             (dsr_a),
      .ring_indicate_b_n_o         (ri_b),
      .carrier_detect_b_n_o        (cd_b),
      .set_ready_b_n_o             (dsr_b),
      .uart_tx_active_i            (tx_act),
      .uart_rts_n_i                (rts_in),
      .rts_n_o                     (rts_n),
      .irda_fast_mode_o            (irda_fast),
      .irda_pulse_sixteenths_o     (pulse),
      .gpio_irq_o                  (irq),
      .soft_rst_o                  (srst)
   );

   task automatic give_verdict;
      $display("checks %0d, failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string s);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: %s got %h want %h", $time, s, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      u_glf_host_model.wr(a, d);
   endtask

   task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string s);
      logic [7:0] d;
      u_glf_host_model.rd(a, d);
      chk(d, e, s);
   endtask

   task automatic t_reset;
      rchk(OFS_IRQ_EN, 8'h00, "en rst");
      rchk(OFS_FUNC, 8'h00, "func rst");
      rchk(OFS_EXTRA, 8'h00, "extra rst");
      rchk(OFS_STATE, 8'hff, "state rst");
   endtask

   // reserved bits, unmapped offset and both pulse widths
   task automatic t_fields;
      wreg(OFS_FUNC, 8'hf7);
      rchk(OFS_FUNC, 8'h07, "func mask");
      wreg(OFS_FUNC, 8'h00);
      wreg(OFS_EXTRA, 8'hff);
      rchk(OFS_EXTRA, 8'hb0, "extra mask");
      chk({irda_fast, 4'h0, pulse}, 8'h84, "fast pulse");
      wreg(OFS_EXTRA, 8'h00);
      cyc(1);
      chk({irda_fast, 4'h0, pulse}, 8'h03, "std pulse");
      rchk(4'hd, 8'h00, "unmapped");
   endtask

   // locked extra register reads zero and drops writes
   task automatic t_lock;
      wreg(OFS_EXTRA, 8'h80);
      u_glf_host_model.lock(1'b1);
      wreg(OFS_EXTRA, 8'h10);
      rchk(OFS_EXTRA, 8'h00, "locked rd");
      u_glf_host_model.lock(1'b0);
      rchk(OFS_EXTRA, 8'h80, "locked wr");
      wreg(OFS_EXTRA, 8'h00);
   endtask

   // every mix of auto direction, polarity, transmitter and uart rts
   task automatic t_rts;
      logic [7:0] e;
      logic       x;
      for (int m = 0; m < 4; m++)
      begin
         e = {2'b00, m[1:0], 4'h0};
         wreg(OFS_EXTRA, e);
         for (int k = 0; k < 4; k++)
         begin
            tx_act = k[0];
            rts_in = k[1];
            x = e[4] ? (e[5] ? tx_act : !tx_act) : rts_in;
            cyc(2);
            chk({7'h0, rts_n}, {7'h0, x}, "rts");
         end
      end
   endtask

   task automatic t_irq;
      pins[3] = 1'b0;
      cyc(6);
      chk({7'h0, irq}, 8'h00, "masked");
      wreg(OFS_IRQ_EN, 8'h08);
      cyc(5);
      chk({7'h0, irq}, 8'h01, "raised");
      pins[3] = 1'b1;
      cyc(5);
      chk({7'h0, irq}, 8'h00, "withdrawn");
   endtask

   // a short glitch is held until the host reads it
   task automatic t_latch;
      logic [7:0] d;
      wreg(OFS_FUNC, 8'h01);
      pins[3] = 1'b0;
      cyc(5);
      pins[3] = 1'b1;
      cyc(5);
      chk({7'h0, irq}, 8'h01, "held irq");
      rchk(OFS_STATE, 8'hf7, "held lvl");
      u_glf_host_model.rd(OFS_STATE, d);
      cyc(4);
      chk({7'h0, irq}, 8'h00, "read clr");
      wreg(OFS_FUNC, 8'h00);
   endtask

   task automatic t_modem;
      wreg(OFS_FUNC, 8'h06);
      pins  = 8'h22;
      dtr_a = 1'b0;
      dtr_b = 1'b0;
      cyc(5);
      chk({7'h0, irq}, 8'h00, "modem irq");
      chk({6'h0, ri_a, ri_b}, 8'h00, "ri low");
      chk({4'h0, cd_a, dsr_a, cd_b, dsr_b}, 8'h00, "cd dsr low");
      chk({4'h0, pin_o[5], oe_n[5], pin_o[1], oe_n[1]}, 8'h00, "dtr drive");
      pins  = 8'hff;
      dtr_a = 1'b1;
      dtr_b = 1'b1;
      cyc(5);
      chk({6'h0, ri_a, ri_b}, 8'h03, "ri high");
      chk({4'h0, cd_a, dsr_a, cd_b, dsr_b}, 8'h0f, "cd dsr high");
      chk({6'h0, pin_o[5], pin_o[1]}, 8'h03, "dtr high");
      wreg(OFS_FUNC, 8'h00);
   endtask

   task automatic t_io;
      wreg(OFS_DIR, 8'h0f);
      wreg(OFS_STATE, 8'ha5);
      cyc(1);
      chk(oe_n, 8'hf0, "dir");
      chk({4'h0, pin_o[3:0]}, 8'h05, "drive");
      wreg(OFS_DIR, 8'h00);
   endtask

   task automatic t_srst;
      int n;
      n = 0;
      wreg(OFS_FUNC, 8'h08);
      while (srst === 1'b1 && n < 10)
      begin
         n++;
         cyc(1);
      end
      chk(8'(n), 8'(SOFT_RST_CNT), "srst len");
      cyc(2);
      rchk(OFS_FUNC, 8'h00, "self clr");
      rchk(OFS_IRQ_EN, 8'h00, "srst regs");
   endtask

   // main sequence
   initial
   begin
      cyc(5);
      rst = 1'b0;
      t_reset;
      t_fields;
      t_lock;
      t_rts;
      t_irq;
      t_latch;
      t_modem;
      t_io;
      t_srst;
      give_verdict;
   end

   // the whole run needs well under a thousand cycles
   initial
   begin
      repeat (4000) @(posedge clk);
      n_fail++;
      give_verdict;
   end
endmodule
